// *** hw/wdp_watchdog.sv ***
// file: watchdog with prescaler, APB register slave and core strobes
//
// Function
// - counter advances on its own oscillator only
// - expiry while awake resets the device
// - expiry while asleep wakes the device instead
// - enable fuse bit 2 zero disables watchdog
// - base period 18 ms without prescaler
// - option register assigns prescaler up to 1:128
// - clear or sleep resets counter, and prescaler while assigned
// - any expiry drives timeout status bit low
// - sleep clears counter, sets timeout, clears powerdown
// - sleep with pending interrupt is a no-op
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module wdp_watchdog #(
  parameter int unsigned BASE_TICKS = wdp_pkg::WD_BASE_TICKS,
  parameter int unsigned CNT_W      = wdp_pkg::WD_CNT_W
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // free-running watchdog oscillator pin, asynchronous to clk_i
  input  wire logic                     wd_osc_i,
  // configuration word strap, caught once after reset release
  input  wire logic [7:0]               config_word_i,
  // processor core
  input  wire wdp_pkg::wdp_core_req_t   core_req_i,
  output wdp_pkg::wdp_core_rsp_t        core_rsp_o,
  // APB slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [wdp_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic [31:0]                   prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // interrupt
  output logic                          irq_o
);

  if (BASE_TICKS < 1 || BASE_TICKS >= (64'h1 << CNT_W)) begin : g_chk
    $error("BASE_TICKS must be at least 1 and fit in CNT_W bits");
  end

  // the index decode and the read word bound the layout
  if (wdp_pkg::APB_AW != 16) begin : g_chk_aw
    $error("APB_AW must be 16 for the word index decode");
  end
  if (CNT_W > 32) begin : g_chk_cnt
    $error("CNT_W must fit the 32-bit read word");
  end
  if (wdp_pkg::CFG_WDEN_BIT > 7 || wdp_pkg::OPT_ASSIGN_BIT > 7
      || wdp_pkg::OPT_PS_LSB > 5) begin : g_chk_fld
    $error("option or configuration field outside its byte");
  end
  if (wdp_pkg::EV_W < 2 || wdp_pkg::EV_W > 32) begin : g_chk_ev
    $error("event width must hold the reset and wake bits");
  end

  typedef struct packed {
    logic [7:0]              option;
    logic [7:0]              config_word;
    logic                    cfg_loaded;
    logic [CNT_W-1:0]        count;
    logic                    to_n;
    logic                    pwrdn_n;
    logic                    asleep;
    logic                    rst_pulse;
    logic                    wake_pulse;
    logic [wdp_pkg::EV_W-1:0] ev_status;
    logic [wdp_pkg::EV_W-1:0] ev_mask;
    logic [31:0]             rdata;
  } wdp_state_t;

  wdp_state_t st_reg;
  wdp_state_t st_next;

  logic             osc_tick;
  logic             presc_tick;
  logic             assigned;
  logic             enabled;
  logic             wd_tick;
  logic             sleep_taken;
  logic             wd_clear;
  logic             expire;
  logic             setup_ph;
  logic             access_ph;
  logic             wr_done;
  logic             hit_option;
  logic             hit_config;
  logic             hit_status;
  logic             hit_event;
  logic             hit_mask;
  logic             hit_count;
  logic             mapped;
  logic             read_only;
  logic [31:0]      rd_mux;
  logic [wdp_pkg::EV_W-1:0] ev_set;
  logic [wdp_pkg::EV_W-1:0] ev_upd;
  logic             wr_option;
  logic             wr_mask;
  logic             wr_event;
  logic             bus_err;

  // oscillator edges, brought into the clk_i domain
  wdp_osc_sync u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .osc_i   (wd_osc_i),
    .tick_o  (osc_tick)
  );

  // prescaler only sees ticks while it is assigned to the watchdog
  wdp_prescaler #(
    .W (wdp_pkg::PRESC_W)
  ) u_presc (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (osc_tick & assigned),
    .clear_i (wd_clear & assigned),
    .ratio_i (st_reg.option[wdp_pkg::OPT_PS_LSB +: 3]),
    .tick_o  (presc_tick)
  );

  // watchdog configuration and tick source
  assign assigned = st_reg.option[wdp_pkg::OPT_ASSIGN_BIT];
  assign enabled  = st_reg.cfg_loaded
                  & st_reg.config_word[wdp_pkg::CFG_WDEN_BIT];
  assign wd_tick  = enabled & (assigned ? presc_tick : osc_tick);

  // sleep is refused while an enabled interrupt is pending
  assign sleep_taken = core_req_i.sleep_instruction
                     & ~core_req_i.irq_pending;
  assign wd_clear    = core_req_i.clear_watchdog_instruction
                     | sleep_taken;

  // expiry on the tick that completes the base period
  assign expire = wd_tick & ~wd_clear
                & (st_reg.count == CNT_W'(BASE_TICKS - 1));

  // APB phase decode
  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;

  // register map, byte address is the word index times four:
  //   option  index 0x081   rw   [3] prescaler assign, [2:0] ratio
  //   config  index 0x2007  ro   strap, [2] watchdog enable fuse
  //   status  index 0x100   ro   [0] timeout_n, [1] powerdown_n, [2] asleep
  //   event   index 0x101   w1c  [0] expiry reset, [1] expiry wake
  //   mask    index 0x102   rw   same layout as event
  //   count   index 0x103   ro   live watchdog counter

  // address decode: word aligned, index times four
  always_comb begin
    hit_option = (paddr_i[15:2] == wdp_pkg::OPTION_IDX);
    hit_config = (paddr_i[15:2] == wdp_pkg::CONFIG_IDX);
    hit_status = (paddr_i[15:2] == wdp_pkg::STATUS_IDX);
    hit_event  = (paddr_i[15:2] == wdp_pkg::EVENT_IDX);
    hit_mask   = (paddr_i[15:2] == wdp_pkg::MASK_IDX);
    hit_count  = (paddr_i[15:2] == wdp_pkg::COUNT_IDX);
    mapped     = (paddr_i[1:0] == 2'h0)
               & (hit_option | hit_config | hit_status
                  | hit_event | hit_mask | hit_count);
    read_only  = hit_config | hit_status | hit_count;
  end

  // read data mux, sampled into a flop during the setup cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (mapped) begin
      if (hit_option) begin
        rd_mux[7:0] = st_reg.option;
      end else if (hit_config) begin
        rd_mux[7:0] = st_reg.config_word;
      end else if (hit_status) begin
        rd_mux[wdp_pkg::ST_TO_BIT]    = st_reg.to_n;
        rd_mux[wdp_pkg::ST_PWRDN_BIT] = st_reg.pwrdn_n;
        rd_mux[wdp_pkg::ST_SLEEP_BIT] = st_reg.asleep;
      end else if (hit_event) begin
        rd_mux[wdp_pkg::EV_W-1:0] = st_reg.ev_status;
      end else if (hit_mask) begin
        rd_mux[wdp_pkg::EV_W-1:0] = st_reg.ev_mask;
      end else begin
        rd_mux[CNT_W-1:0] = st_reg.count;
      end
    end
  end

  // a write lands at the access edge, only on a mapped writable word
  assign wr_done = access_ph & pwrite_i & mapped & ~read_only;

  // per-register write strobes
  assign wr_option = wr_done & hit_option;
  assign wr_mask   = wr_done & hit_mask;
  assign wr_event  = wr_done & hit_event;

  // events raised by an expiry this cycle
  always_comb begin
    ev_set = '0;
    ev_set[wdp_pkg::EV_RESET_BIT] = expire & ~st_reg.asleep;
    ev_set[wdp_pkg::EV_WAKE_BIT]  = expire & st_reg.asleep;
  end

  // sticky event bits, one slice each: a new event wins over its clear
  for (genvar b = 0; b < wdp_pkg::EV_W; b++) begin : g_ev
    assign ev_upd[b] = ev_set[b]
                     | (st_reg.ev_status[b] & ~(wr_event & pwdata_i[b]));
  end

  // next state of the whole block
  always_comb begin
    st_next            = st_reg;
    st_next.rst_pulse  = 1'b0;
    st_next.wake_pulse = 1'b0;

    // catch the configuration strap once after reset release
    if (!st_reg.cfg_loaded) begin
      st_next.config_word = config_word_i;
      st_next.cfg_loaded  = 1'b1;
    end

    // counter: cleared by instructions, forced to zero while the fuse is off
    if (!enabled) begin
      st_next.count = '0;
    end else if (wd_clear || expire) begin
      st_next.count = '0;
    end else if (wd_tick) begin
      st_next.count = st_reg.count + CNT_W'(1);
    end

    // clear-watchdog instruction sets both status bits
    if (core_req_i.clear_watchdog_instruction) begin
      st_next.to_n    = 1'b1;
      st_next.pwrdn_n = 1'b1;
    end

    // accepted sleep: counter cleared, status updated
    if (sleep_taken) begin
      st_next.to_n   = 1'b1;
      st_next.pwrdn_n = 1'b0;
      st_next.asleep = 1'b1;
    end

    // expiry: reset when awake, wake when asleep
    if (expire) begin
      st_next.to_n = 1'b0;
      if (st_reg.asleep) begin
        st_next.wake_pulse = 1'b1;
        st_next.asleep     = 1'b0;
      end else begin
        st_next.rst_pulse = 1'b1;
      end
    end

    // register writes; a new ratio takes effect at once
    if (wr_option) begin
      st_next.option = pwdata_i[7:0];
    end
    if (wr_mask) begin
      st_next.ev_mask = pwdata_i[wdp_pkg::EV_W-1:0];
    end

    // sticky events: write one clears, a new event wins
    st_next.ev_status = ev_upd;

    // read data captured in the setup cycle, held through access
    if (setup_ph) begin
      st_next.rdata = rd_mux;
    end
  end

  // one register bank for all state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg            <= '0;
      st_reg.option     <= wdp_pkg::OPTION_RST;
      st_reg.ev_mask    <= wdp_pkg::MASK_RST;
      st_reg.to_n       <= 1'b1;
      st_reg.pwrdn_n    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // APB answers: one access cycle, error on unmapped or read-only write
  assign pready_o  = access_ph;
  assign bus_err   = ~mapped | (pwrite_i & read_only);
  assign pslverr_o = access_ph & bus_err;
  assign prdata_o  = st_reg.rdata;

  // core outputs, all from flops
  always_comb begin
    core_rsp_o.device_reset         = st_reg.rst_pulse;
    core_rsp_o.wake                 = st_reg.wake_pulse;
    core_rsp_o.timeout_status_bit   = st_reg.to_n;
    core_rsp_o.powerdown_status_bit = st_reg.pwrdn_n;
    core_rsp_o.asleep               = st_reg.asleep;
  end

  // level interrupt while any unmasked event is pending
  assign irq_o = |(st_reg.ev_status & st_reg.ev_mask);

endmodule : wdp_watchdog
`default_nettype wire

// *** hw/wdp_pkg.sv ***
// package: register map, field layout, timing and carrier types of the watchdog
`default_nettype none
package wdp_pkg;

  // register indices; the byte address is four times the index
  localparam logic [13:0] OPTION_IDX = 14'h0081; // prescaler_option_control
  localparam logic [13:0] CONFIG_IDX = 14'h2007; // device_configuration_word
  localparam logic [13:0] STATUS_IDX = 14'h0100; // timeout / powerdown / asleep
  localparam logic [13:0] EVENT_IDX  = 14'h0101; // sticky events, write 1 clears
  localparam logic [13:0] MASK_IDX   = 14'h0102; // event interrupt mask
  localparam logic [13:0] COUNT_IDX  = 14'h0103; // live watchdog_counter value

  // option register fields
  localparam int unsigned OPT_ASSIGN_BIT = 3; // prescaler_assign_select
  localparam int unsigned OPT_PS_LSB  = 0; // prescale_ratio_select [2:0]
  localparam logic [7:0]  OPTION_RST  = 8'h00;

  // configuration word fields
  localparam int unsigned CFG_WDEN_BIT = 2; // watchdog_enable_fuse

  // status register fields
  localparam int unsigned ST_TO_BIT    = 0; // timeout_status_bit, active low
  localparam int unsigned ST_PWRDN_BIT = 1; // powerdown_status_bit, active low
  localparam int unsigned ST_SLEEP_BIT = 2; // core is asleep

  // event register fields
  localparam int unsigned EV_RESET_BIT = 0; // time-out caused a device reset
  localparam int unsigned EV_WAKE_BIT  = 1; // time-out woke the device
  localparam int unsigned EV_W         = 2;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;

  // timing: nominal base period and the watchdog oscillator rate
  localparam int unsigned WD_BASE_PERIOD_US = 18000; // 18 ms
  localparam int unsigned WD_OSC_FREQ_KHZ   = 1000;
  localparam int unsigned WD_BASE_TICKS =
    (WD_BASE_PERIOD_US * WD_OSC_FREQ_KHZ) / 1000;
  localparam int unsigned WD_CNT_W = 16;
  localparam int unsigned PRESC_W   = 7;  // up to 1:128
  localparam int unsigned APB_AW    = 16;

  // instruction strobes coming from the processor core
  typedef struct packed {
    logic clear_watchdog_instruction; // one-cycle pulse
    logic sleep_instruction;          // one-cycle pulse
    logic irq_pending;                // enabled interrupt already pending
  } wdp_core_req_t;

  // what the watchdog reports back to the core
  typedef struct packed {
    logic device_reset;          // one-cycle pulse
    logic wake;                  // one-cycle pulse
    logic timeout_status_bit;    // active low
    logic powerdown_status_bit;  // active low
    logic asleep;
  } wdp_core_rsp_t;

endpackage : wdp_pkg
`default_nettype wire

// *** hw/wdp_osc_sync.sv ***
// file: synchroniser and rising-edge detector for the watchdog oscillator pin
`timescale 1ns/1ps
`default_nettype none
module wdp_osc_sync (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic osc_i,
  output logic      tick_o
);

  typedef struct packed {
    logic       meta;
    logic       sync;
    logic       prev;
    logic [2:0] vld;
  } wdp_sync_st_t;

  wdp_sync_st_t st_reg;
  wdp_sync_st_t st_next;

  // two stages, then a third flop only for the edge detector
  always_comb begin
    st_next      = st_reg;
    st_next.meta = osc_i;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
    st_next.vld  = {st_reg.vld[1:0], 1'b1};
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // no edge until prev holds a real sample, so a pin already high at
  // reset release is not taken for a rising edge
  assign tick_o = st_reg.vld[2] & st_reg.sync & ~st_reg.prev;

endmodule : wdp_osc_sync
`default_nettype wire

// *** hw/wdp_prescaler.sv ***
// file: shared power-of-two prescaler, 1:1 through 1:128
`timescale 1ns/1ps
`default_nettype none
module wdp_prescaler #(
  parameter int unsigned W = wdp_pkg::PRESC_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         tick_i,
  input  wire logic         clear_i,
  input  wire logic [2:0]   ratio_i,
  output logic              tick_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } wdp_presc_st_t;

  wdp_presc_st_t st_reg;
  wdp_presc_st_t st_next;
  logic [W-1:0]  mask;

  if (W != 7) begin : g_chk
    $error("prescaler width must be 7 for ratios up to 1:128");
  end

  // low ratio bits of the count must all be one to pass a tick
  assign mask   = W'((8'h01 << ratio_i) - 8'h01);
  assign tick_o = tick_i & ((st_reg.cnt | ~mask) == {W{1'b1}});

  always_comb begin
    st_next = st_reg;
    if (clear_i) begin
      st_next.cnt = '0;
    end else if (tick_i) begin
      st_next.cnt = st_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : wdp_prescaler
`default_nettype wire

// *** test/wdp_watchdog_props.sv ***
// checker: port properties of the watchdog block
`timescale 1ns/1ps
`default_nettype none
module wdp_chk (
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  input wire logic [7:0]             config_word_i,
  input wire wdp_pkg::wdp_core_req_t core_req_i,
  input wire wdp_pkg::wdp_core_rsp_t core_rsp_o,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // every expiry leaves the time-out flag low
  property p_rst_to;
    core_rsp_o.device_reset |-> !core_rsp_o.timeout_status_bit;
  endproperty
  a_rst_to: assert property (p_rst_to)
    else $error("reset pulse with timeout flag high");
  property p_wake_to;
    core_rsp_o.wake |-> !core_rsp_o.timeout_status_bit;
  endproperty
  a_wake_to: assert property (p_wake_to)
    else $error("wake pulse with timeout flag high");
  // an expiry either resets or wakes, never both
  property p_wake_excl;
    core_rsp_o.wake |-> !core_rsp_o.device_reset;
  endproperty
  a_wake_excl: assert property (p_wake_excl)
    else $error("wake and reset together");
  // reset request is a single pulse
  property p_rst_pulse;
    core_rsp_o.device_reset |=> !core_rsp_o.device_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pulse longer than one cycle");
  // clear strobe restores both status flags
  property p_clear;
    core_req_i.clear_watchdog_instruction
      && !core_req_i.sleep_instruction |=>
      core_rsp_o.timeout_status_bit && core_rsp_o.powerdown_status_bit;
  endproperty
  a_clear: assert property (p_clear)
    else $error("status not restored by clear");
  // sleep without pending interrupt
  property p_sleep;
    core_req_i.sleep_instruction && !core_req_i.irq_pending
      |=> core_rsp_o.timeout_status_bit && !core_rsp_o.powerdown_status_bit
          && core_rsp_o.asleep;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep status wrong");
  // sleep with pending interrupt does nothing
  property p_sleep_nop;
    core_req_i.sleep_instruction && core_req_i.irq_pending &&
      !core_req_i.clear_watchdog_instruction
      |=> $stable(core_rsp_o.powerdown_status_bit)
          && !$rose(core_rsp_o.asleep);
  endproperty
  a_sleep_nop: assert property (p_sleep_nop)
    else $error("sleep acted despite pending interrupt");
  // fuse off means no expiry at all
  property p_fuse;
    !config_word_i[wdp_pkg::CFG_WDEN_BIT]
      |-> !core_rsp_o.device_reset && !core_rsp_o.wake;
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("expiry with watchdog fused off");
  // bus answers in the first access cycle, error only there
  property p_apb;
    (psel_i && penable_i |-> pready_o) and
      (pslverr_o |-> psel_i && penable_i);
  endproperty
  a_apb: assert property (p_apb)
    else $error("bus answer timing wrong");
endmodule : wdp_chk

bind wdp_watchdog wdp_chk u_wdp_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .config_word_i(config_word_i),
  .core_req_i(core_req_i), .core_rsp_o(core_rsp_o), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o)
);
`default_nettype wire

// *** test/wdp_core_model.sv ***
// partner: processor core strobes and watchdog oscillator
`timescale 1ns/1ps
`default_nettype none
module wdp_core_model (
  input  wire logic                 clk_i,
  output var wdp_pkg::wdp_core_req_t req_o,
  output var logic                  osc_o
);
  // free-running oscillator, phase unrelated to clk_i
  // offset so that no pin edge lands on a clk_i edge
  initial begin
    osc_o = 1'b0;
    #5;
    forever #170 osc_o = ~osc_o;
  end
  initial req_o = '0;
  // one-cycle clear strobe
  task automatic clr();
    @(posedge clk_i);
    req_o.clear_watchdog_instruction <= 1'b1;
    @(posedge clk_i);
    req_o.clear_watchdog_instruction <= 1'b0;
  endtask : clr
  // one-cycle sleep strobe, optionally with an interrupt pending
  task automatic slp(input logic irq);
    @(posedge clk_i);
    req_o.sleep_instruction <= 1'b1;
    req_o.irq_pending       <= irq;
    @(posedge clk_i);
    req_o <= '0;
  endtask : slp
endmodule : wdp_core_model
`default_nettype wire

// *** test/tb_top.sv ***
// testbench: registers, expiry, prescaler, sleep and fuse tests
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BT = 3;
  localparam logic [15:0] A_OPT = {wdp_pkg::OPTION_IDX, 2'b00};
  localparam logic [15:0] A_CFG = {wdp_pkg::CONFIG_IDX, 2'b00};
  localparam logic [15:0] A_ST  = {wdp_pkg::STATUS_IDX, 2'b00};
  localparam logic [15:0] A_EV  = {wdp_pkg::EVENT_IDX, 2'b00};
  localparam logic [15:0] A_MSK = {wdp_pkg::MASK_IDX, 2'b00};
  localparam logic [15:0] A_CNT = {wdp_pkg::COUNT_IDX, 2'b00};
  logic                   clk    = 1'b0;
  logic                   rst_b  = 1'b0;
  logic [7:0]             cfg    = 8'h04;
  logic                   psel   = 1'b0;
  logic                   pen    = 1'b0;
  logic                   pwr    = 1'b0;
  logic [15:0]            paddr  = 16'h0000;
  logic [31:0]            pwdata = 32'h0000_0000;
  logic [31:0]            prdata;
  logic                   pready, pslverr, irq, osc;
  wdp_pkg::wdp_core_req_t req;
  wdp_pkg::wdp_core_rsp_t rsp;
  int                     miscompares = 0;
  int                     checked = 0;
  int                     fires = 0;

  always #20 clk = ~clk;
  // count every expiry seen at the core side
  always @(posedge clk) if (rsp.device_reset === 1'b1 || rsp.wake === 1'b1)
    fires++;

  wdp_core_model u_wdp_core_model (.clk_i(clk), .req_o(req), .osc_o(osc));
  wdp_watchdog #(.BASE_TICKS(BT)) u_wdp_watchdog (
    .clk_i(clk), .rst_b_i(rst_b), .wd_osc_i(osc), .config_word_i(cfg),
    .core_req_i(req), .core_rsp_o(rsp), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // one bus transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  // wait for an expiry pulse, bounded
  task automatic wexp(output logic wk, output time el);
    int  n;
    time t0;
    n = 0;
    t0 = $time;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.device_reset !== 1'b1 && rsp.wake !== 1'b1 && n < 5000);
    wk = rsp.wake;
    el = $time - t0;
  endtask : wexp
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog against a hung run
  initial begin
    #(40 * 40000);
    miscompares++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    logic        wk;
    time         el;
    int          n;
    int          rc;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rd(A_OPT, 32'h0);
    rd(A_MSK, 32'h0);
    rd(A_ST, 32'h3);
    rd(A_CFG, 32'h4);
    apb(1'b0, 16'h0300, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, A_CFG, 32'h0, r, e);
    chk(32'(e), 32'h1);
    // period without prescaler, then every ratio
    for (int i = 0; i < 9; i++) begin
      n = (i == 0) ? BT : (BT << (i - 1));
      u_wdp_core_model.clr();
      wr(A_OPT, (i == 0) ? 32'h0 : 32'(8 + i - 1));
      u_wdp_core_model.clr();
      wexp(wk, el);
      chk(32'(wk), 32'h0);
      chk(32'(el >= (n - 1) * 340 && el <= n * 340 + 400), 32'h1);
    end
    rd(A_ST, 32'h2);
    rd(A_EV, 32'h1);
    chk(32'(irq), 32'h0);
    wr(A_MSK, 32'h1);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(A_EV, 32'h1);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    // regular clearing keeps the watchdog from firing
    u_wdp_core_model.clr();
    wr(A_OPT, 32'h0);
    rc = fires;
    repeat (20) begin
      repeat (10) @(posedge clk);
      u_wdp_core_model.clr();
    end
    chk(32'(fires), 32'(rc));
    // sleep with an interrupt pending, then a real sleep
    u_wdp_core_model.slp(1'b1);
    rd(A_ST, 32'h3);
    u_wdp_core_model.slp(1'b0);
    fork
      wexp(wk, el);
      rd(A_ST, 32'h5);
    join
    chk(32'(wk), 32'h1);
    chk(32'(el >= (BT - 1) * 340 && el <= BT * 340 + 400), 32'h1);
    rd(A_ST, 32'h0);
    rd(A_EV, 32'h2);
    // fuse cleared: the watchdog stays quiet
    rst_b <= 1'b0;
    cfg   <= 8'h00;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rc = fires;
    repeat (300) @(posedge clk);
    chk(32'(fires), 32'(rc));
    rd(A_CNT, 32'h0);
    rd(A_CFG, 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
